/* core/icc_filter.sv */
// Purpose: one-channel input noise filter counted in millisecond ticks
// Assumes: din synchronous to core_clk
// Notes: level zero passes the input through one flip-flop
`timescale 1ns/1ps
`default_nettype none
module icc_filter
   import icc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // control
   input  wire logic        ms_tick,
   input  wire logic [15:0] level,
   // data
   input  wire logic        din,
   output logic             dout
);
   typedef struct packed {
      logic        out_r;
      logic [15:0] cnt_r;
   } icc_filt_type;

   icc_filt_type st_r;
   icc_filt_type st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (level == 16'h0000) begin
         st_nxt.out_r = din;
         st_nxt.cnt_r = 16'h0000;
      end else if (din == st_r.out_r) begin
         st_nxt.cnt_r = 16'h0000;
      end else if (ms_tick) begin
         if (st_r.cnt_r + 16'h0001 >= level) begin
            st_nxt.out_r = din;
            st_nxt.cnt_r = 16'h0000;
         end else begin
            st_nxt.cnt_r = st_r.cnt_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.out_r;

   chk_bypass_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      (level == 16'h0000) |=> (dout == $past(din)))
      else $error("filter bypass does not follow input");
   chk_short_glitch: assert property (@(posedge core_clk) disable iff (!rst_n)
      (level != 16'h0000 && din != dout && !ms_tick) |=> $stable(dout))
      else $error("filter passed change without a tick");
endmodule
`default_nettype wire

/* core/icc_pkg.sv */
// Purpose: constants and register map for the input conditioning and counter block
// Assumes: core_clk at 200 MHz, eight universal channels
// Notes: byte addresses on the Avalon-MM slave, one 32-bit word per register
// Behaviour
// - writing one to clear-low-latch clears all low latches; zero does nothing.
// - the low-latch clear acts on all input channels at once.
// - filter level 1 to 6500 ms suppresses shorter input changes.
// - filter level zero bypasses the filter and is the reset value.
// - per-channel counter enable; pulses counted only while enabled.
// - per-channel clear command resets that channel's counter.
// - each counter has a programmable preset used as its starting value.
// - per-channel frequency enable; result produced only while enabled.
// - 1000 ms mode counts pulses over 1000 ms, 1 Hz resolution.
// - 100 ms mode counts pulses over 100 ms, 10 Hz resolution.
// - single-pulse mode derives frequency from one pulse period, updates per pulse.
// - result averaged over 1, 2, 4 or 8 consecutive samples.
// - dynamic mode makes a channel an output once an output request addresses it.
// - static mode direction follows a config bit, one input, zero output.
// - host writes eight output values; device drives each output to it.
package icc_pkg;
   localparam int          NCH          = 8;
   localparam int          CLK_HZ       = 200_000_000;
   localparam int          US_NS        = 1000;
   localparam int          US_CYC       = (US_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int          MS_CYC_DFLT  = CLK_HZ / 1000;
   localparam int          WIN_LONG_MS  = 1000;
   localparam int          WIN_SHORT_MS = 100;
   localparam int          FILT_MAX_MS  = 6500;
   localparam logic [15:0] FILT_RST     = 16'h0000;
   // results in hundredths of a hertz
   localparam logic [31:0] SCALE_LONG   = 32'h0000_0064;
   localparam logic [31:0] SCALE_SHORT  = 32'h0000_03E8;
   localparam logic [31:0] SP_K         = 32'h05F5_E100;
   localparam logic [7:0]  A_CTRL       = 8'h00;
   localparam logic [7:0]  A_FILT       = 8'h04;
   localparam logic [7:0]  A_CFG        = 8'h08;
   localparam logic [7:0]  A_DIR        = 8'h0C;
   localparam logic [7:0]  A_DOUT       = 8'h10;
   localparam logic [7:0]  A_CCLR       = 8'h14;
   localparam logic [7:0]  A_STAT       = 8'h18;
   localparam logic [7:0]  A_IRQS       = 8'h1C;
   localparam logic [7:0]  A_IRQM       = 8'h20;
   localparam logic [7:0]  A_PRESET     = 8'h40;
   localparam logic [7:0]  A_COUNT      = 8'h60;
   localparam logic [7:0]  A_FREQ       = 8'h80;
   localparam int          B_COMMIT     = 0;
   localparam int          B_CLRLO      = 1;
   localparam int          F_CNTEN      = 0;
   localparam int          F_FREQEN     = 8;
   localparam int          F_MODE       = 16;
   localparam int          F_AVG        = 18;
   localparam int          B_DYN        = 20;
   localparam int          F_DOREQ      = 8;
   localparam logic [7:0]  DIR_RST      = 8'hFF;
   localparam logic [1:0]  MODE_LONG    = 2'h0;
   localparam logic [1:0]  MODE_SHORT   = 2'h1;
   localparam logic [1:0]  MODE_SINGLE  = 2'h2;
endpackage

/* core/icc_top.sv */
// Purpose: input conditioning, pulse counters, frequency meter and universal DIO
// Assumes: Avalon-MM slave with waitrequest, pins synchronous to core_clk
// Notes: shadow configuration becomes active on commit
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module icc_top
   import icc_pkg::*;
#(
   parameter int MS_CYC = MS_CYC_DFLT
)(
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            rst_n,
   // avalon-mm slave
   input  wire logic [7:0]      avs_address,
   input  wire logic            avs_read,
   input  wire logic            avs_write,
   input  wire logic [31:0]     avs_writedata,
   output logic [31:0]          avs_readdata,
   output logic                 avs_waitrequest,
   // universal channel pins
   input  wire logic [NCH-1:0]  dio_i,
   output logic [NCH-1:0]       dio_o,
   output logic [NCH-1:0]       dio_oe,
   // interrupt
   output logic                 irq
);
   typedef struct packed {
      logic                      ack_r;
      logic [31:0]               rdata_r;
      logic [15:0]               sh_filt_r;
      logic [20:0]               sh_cfg_r;
      logic [NCH-1:0]            sh_dir_r;
      logic [15:0]               filt_r;
      logic [NCH-1:0]            cnten_r;
      logic [NCH-1:0]            freqen_r;
      logic [1:0]                mode_r;
      logic [1:0]                avg_r;
      logic                      dyn_r;
      logic [NCH-1:0]            dir_r;
      logic [NCH-1:0]            dout_r;
      logic [NCH-1:0]            doreq_r;
      logic [NCH-1:0]            latch_r;
      logic [NCH-1:0]            irqs_r;
      logic [NCH-1:0]            irqm_r;
      logic [NCH-1:0]            in_d_r;
      logic [7:0]                us_r;
      logic [17:0]               ms_r;
      logic [9:0]                win_r;
      logic [NCH-1:0][31:0]      preset_r;
      logic [NCH-1:0][31:0]      count_r;
      logic [NCH-1:0][31:0]      freq_r;
      logic [NCH-1:0][15:0]      pulses_r;
      logic [NCH-1:0][27:0]      per_r;
      logic [NCH-1:0]            perv_r;
      logic [NCH-1:0][34:0]      acc_r;
      logic [NCH-1:0][3:0]       nsamp_r;
   } icc_state_type;

   icc_state_type st_r;
   icc_state_type st_nxt;
   logic [NCH-1:0] filt_in;
   logic [NCH-1:0] dir_in;
   logic           ms_tick;
   logic           us_tick;
   logic           win_end;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
      hit = (a[7:5] == base[7:5]);
   endfunction

   function automatic logic [3:0] avg_len(input logic [1:0] sel);
      avg_len = 4'h1 << sel;
   endfunction

   assign ms_tick = (st_r.ms_r == 18'(MS_CYC - 1));
   assign us_tick = (st_r.us_r == 8'(US_CYC - 1));
   assign win_end = ms_tick && (st_r.win_r == ((st_r.mode_r == MODE_SHORT) ?
                    10'(WIN_SHORT_MS - 1) : 10'(WIN_LONG_MS - 1)));

   // dynamic: addressed channels turn output; static: config bit
   assign dir_in = st_r.dyn_r ? ~st_r.doreq_r : st_r.dir_r;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_filt
         icc_filter u_filt (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .ms_tick  (ms_tick),
            .level    (st_r.filt_r),
            .din      (dio_i[g]),
            .dout     (filt_in[g])
         );
      end
   endgenerate

   always_comb begin
      logic        wr;
      logic        rd;
      logic [2:0]  ch;
      logic [NCH-1:0] cclr;
      logic [NCH-1:0] rise;
      logic [NCH-1:0] low_now;
      logic        clr_lo;
      logic        restart;
      logic        got;
      logic [31:0] smp;
      logic [34:0] sum;
      wr      = avs_write && st_r.ack_r;
      rd      = avs_read && !st_r.ack_r;
      ch      = avs_address[4:2];
      cclr    = '0;
      rise    = '0;
      low_now = '0;
      clr_lo  = 1'b0;
      restart = 1'b0;
      got     = 1'b0;
      smp     = '0;
      sum     = '0;
      st_nxt  = st_r;
      st_nxt.ack_r = (avs_read || avs_write) && !st_r.ack_r;

      // tick generators
      st_nxt.us_r = us_tick ? 8'h00 : st_r.us_r + 8'h01;
      st_nxt.ms_r = ms_tick ? 18'h00000 : st_r.ms_r + 18'h00001;
      if (ms_tick) begin
         st_nxt.win_r = win_end ? 10'h000 : st_r.win_r + 10'h001;
      end

      // register writes
      if (wr) begin
         case (avs_address)
            A_CTRL: begin
               clr_lo = avs_writedata[B_CLRLO];
               if (avs_writedata[B_COMMIT]) begin
                  st_nxt.filt_r   = st_r.sh_filt_r;
                  st_nxt.cnten_r  = st_r.sh_cfg_r[F_CNTEN +: NCH];
                  st_nxt.freqen_r = st_r.sh_cfg_r[F_FREQEN +: NCH];
                  st_nxt.mode_r   = st_r.sh_cfg_r[F_MODE +: 2];
                  st_nxt.avg_r    = st_r.sh_cfg_r[F_AVG +: 2];
                  st_nxt.dyn_r    = st_r.sh_cfg_r[B_DYN];
                  st_nxt.dir_r    = st_r.sh_dir_r;
                  restart = (st_r.sh_cfg_r[F_MODE +: 2] != st_r.mode_r) ||
                            (st_r.sh_cfg_r[F_AVG +: 2] != st_r.avg_r);
               end
            end
            A_FILT: st_nxt.sh_filt_r = (avs_writedata[15:0] > 16'(FILT_MAX_MS)) ?
                                       16'(FILT_MAX_MS) : avs_writedata[15:0];
            A_CFG:  st_nxt.sh_cfg_r = avs_writedata[20:0];
            A_DIR:  st_nxt.sh_dir_r = avs_writedata[NCH-1:0];
            A_DOUT: begin
               st_nxt.dout_r  = avs_writedata[NCH-1:0];
               st_nxt.doreq_r = st_r.doreq_r | avs_writedata[F_DOREQ +: NCH];
            end
            A_CCLR: cclr = avs_writedata[NCH-1:0];
            A_IRQM: st_nxt.irqm_r = avs_writedata[NCH-1:0];
            default: begin
               if (hit(avs_address, A_PRESET)) begin
                  st_nxt.preset_r[ch] = avs_writedata;
               end
            end
         endcase
      end

      // per-channel input processing
      st_nxt.in_d_r = filt_in;
      for (int i = 0; i < NCH; i++) begin
         rise[i]    = filt_in[i] && !st_r.in_d_r[i] && dir_in[i];
         low_now[i] = !filt_in[i] && dir_in[i];
         if (cclr[i]) begin
            st_nxt.count_r[i] = st_r.preset_r[i];
         end else if (rise[i] && st_r.cnten_r[i]) begin
            st_nxt.count_r[i] = st_r.count_r[i] + 32'h0000_0001;
         end
         got = 1'b0;
         smp = '0;
         if (st_r.mode_r == MODE_SINGLE) begin
            if (us_tick && st_r.per_r[i] != 28'hFFF_FFFF) begin
               st_nxt.per_r[i] = st_r.per_r[i] + 28'h000_0001;
            end
            if (rise[i]) begin
               st_nxt.per_r[i]  = 28'h000_0000;
               st_nxt.perv_r[i] = 1'b1;
               if (st_r.perv_r[i] && st_r.per_r[i] != 28'h000_0000) begin
                  got = 1'b1;
                  smp = SP_K / {4'h0, st_r.per_r[i]};
               end
            end
         end else begin
            st_nxt.pulses_r[i] = st_r.pulses_r[i] + {15'h0000, rise[i]};
            if (win_end) begin
               st_nxt.pulses_r[i] = {15'h0000, rise[i]};
               got = 1'b1;
               smp = (st_r.mode_r == MODE_SHORT) ? 32'(st_r.pulses_r[i] * SCALE_SHORT) :
                     32'(st_r.pulses_r[i] * SCALE_LONG);
            end
         end
         if (got) begin
            sum = st_r.acc_r[i] + {3'h0, smp};
            if (st_r.nsamp_r[i] + 4'h1 >= avg_len(st_r.avg_r)) begin
               st_nxt.freq_r[i]  = 32'(sum >> st_r.avg_r);
               st_nxt.acc_r[i]   = '0;
               st_nxt.nsamp_r[i] = 4'h0;
            end else begin
               st_nxt.acc_r[i]   = sum;
               st_nxt.nsamp_r[i] = st_r.nsamp_r[i] + 4'h1;
            end
         end
         if (!st_r.freqen_r[i] || restart) begin
            st_nxt.acc_r[i]    = '0;
            st_nxt.nsamp_r[i]  = 4'h0;
            st_nxt.pulses_r[i] = 16'h0000;
            st_nxt.perv_r[i]   = 1'b0;
         end
         if (!st_r.freqen_r[i]) begin
            st_nxt.freq_r[i] = 32'h0000_0000;
         end
      end
      if (restart) begin
         st_nxt.win_r = 10'h000;
      end

      // low latch: new lows win over a clear
      st_nxt.latch_r = (clr_lo ? '0 : st_r.latch_r) | low_now;
      st_nxt.irqs_r  = st_r.irqs_r | (low_now & ~st_r.latch_r);
      if (wr && avs_address == A_IRQS) begin
         st_nxt.irqs_r = (st_r.irqs_r & ~avs_writedata[NCH-1:0]) | (low_now & ~st_r.latch_r);
      end

      // register reads
      if (rd) begin
         case (avs_address)
            A_FILT:  st_nxt.rdata_r = {16'h0000, st_r.sh_filt_r};
            A_CFG:   st_nxt.rdata_r = {11'h000, st_r.sh_cfg_r};
            A_DIR:   st_nxt.rdata_r = {24'h000000, st_r.sh_dir_r};
            A_DOUT:  st_nxt.rdata_r = {16'h0000, st_r.doreq_r, st_r.dout_r};
            A_STAT:  st_nxt.rdata_r = {8'h00, dir_in, st_r.in_d_r, st_r.latch_r};
            A_IRQS:  st_nxt.rdata_r = {24'h000000, st_r.irqs_r};
            A_IRQM:  st_nxt.rdata_r = {24'h000000, st_r.irqm_r};
            default: begin
               st_nxt.rdata_r = 32'h0000_0000;
               if (hit(avs_address, A_PRESET)) begin
                  st_nxt.rdata_r = st_r.preset_r[ch];
               end else if (hit(avs_address, A_COUNT)) begin
                  st_nxt.rdata_r = st_r.count_r[ch];
               end else if (hit(avs_address, A_FREQ)) begin
                  st_nxt.rdata_r = st_r.freq_r[ch];
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r          <= '0;
         st_r.filt_r   <= FILT_RST;
         st_r.sh_filt_r <= FILT_RST;
         st_r.dir_r    <= DIR_RST;
         st_r.sh_dir_r <= DIR_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign avs_readdata    = st_r.rdata_r;
   assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack_r;
   assign dio_o           = st_r.dout_r;
   assign dio_oe          = ~dir_in;
   assign irq             = |(st_r.irqs_r & st_r.irqm_r);

   chk_clr_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
      (avs_write && st_r.ack_r && avs_address == A_CTRL && avs_writedata[B_CLRLO])
      |=> (st_r.latch_r == $past(~filt_in & dir_in)))
      else $error("low latch not cleared");
   chk_zero_noop: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r.latch_r != '0 && !(avs_write && avs_address == A_CTRL && avs_writedata[B_CLRLO]))
      |=> ((st_r.latch_r & $past(st_r.latch_r)) == $past(st_r.latch_r)))
      else $error("low latch lost without clear");
   chk_cnt_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r.cnten_r == '0 && !(avs_write && avs_address == A_CCLR))
      |=> $stable(st_r.count_r))
      else $error("counter moved while disabled");
   chk_cnt_preset: assert property (@(posedge core_clk) disable iff (!rst_n)
      (avs_write && st_r.ack_r && avs_address == A_CCLR && avs_writedata[0])
      |=> (st_r.count_r[0] == $past(st_r.preset_r[0])))
      else $error("counter clear did not load preset");
   chk_freq_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      !st_r.freqen_r[2] |=> (st_r.freq_r[2] == 32'h0000_0000))
      else $error("frequency result while disabled");
   chk_static_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
      !st_r.dyn_r |-> (dio_oe == ~st_r.dir_r))
      else $error("static direction wrong");
   chk_dyn_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r.dyn_r && st_r.doreq_r[0]) |-> dio_oe[0])
      else $error("addressed channel not output");
   chk_dout_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
      (avs_write && st_r.ack_r && avs_address == A_DOUT)
      |=> (dio_o == $past(avs_writedata[NCH-1:0])))
      else $error("output value not driven");
   chk_commit_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(avs_write && avs_address == A_CTRL) |=> $stable(st_r.filt_r) && $stable(st_r.mode_r))
      else $error("active config changed without commit");
   chk_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus answer late");
   cov_commit: cover property (@(posedge core_clk) disable iff (!rst_n)
      avs_write && st_r.ack_r && avs_address == A_CTRL && avs_writedata[B_COMMIT]);
   cov_single: cover property (@(posedge core_clk) disable iff (!rst_n)
      st_r.mode_r == MODE_SINGLE && st_r.freq_r[2] != 32'h0000_0000);
   cov_window: cover property (@(posedge core_clk) disable iff (!rst_n) win_end);
   cov_irq: cover property (@(posedge core_clk) disable iff (!rst_n) irq);
endmodule
`default_nettype wire

/* tb/icc_pin_src.sv */
// Purpose: field-side pulse source driving the channel input pins
// Assumes: core_clk from the bench, half period counted in core_clk cycles
// Notes: channels outside run_mask show the static level only
`timescale 1ns/1ps
`default_nettype none
module icc_pin_src
   import icc_pkg::*;
(
   // clock
   input  wire logic            core_clk,
   // bench control
   input  wire logic [NCH-1:0]  level,
   input  wire logic [NCH-1:0]  run_mask,
   input  wire logic [15:0]     half,
   // pins
   output logic [NCH-1:0]       dio_i
);
   logic [15:0] cnt_r = 16'h0000;
   logic        ph_r  = 1'b0;

   always @(posedge core_clk) begin
      if (cnt_r + 16'h0001 >= half) begin
         cnt_r <= 16'h0000;
         ph_r  <= !ph_r;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // square wave on the running channels
   assign dio_i = level ^ (run_mask & {NCH{ph_r}});
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: register-level tests of the input conditioning block
// Assumes: MS_CYC shrunk to 20 cycles so windows are short
// Notes: all checks go through the compare macro
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
   import icc_pkg::*;
   localparam int MSC = 20;
   logic             core_clk = 1'b0;
   logic             rst_n = 1'b0;
   logic [7:0]       avs_address = 8'h00;
   logic             avs_read = 1'b0;
   logic             avs_write = 1'b0;
   logic [31:0]      avs_writedata = 32'h0000_0000;
   logic [31:0]      avs_readdata;
   logic             avs_waitrequest;
   logic [NCH-1:0]   dio_i;
   logic [NCH-1:0]   dio_o;
   logic [NCH-1:0]   dio_oe;
   logic             irq;
   logic [NCH-1:0]   lvl = 8'h00;
   logic [NCH-1:0]   run = 8'h00;
   logic [31:0]      q;
   int               err_count = 0;
   int               check_count = 0;
   // short first so every later mode change restarts the window at commit
   logic [1:0]       md [3] = '{MODE_SHORT, MODE_LONG, MODE_SINGLE};
   int               wt [3] = '{2500, 22000, 3500};
   logic [31:0]      lo [3] = '{32'h0000_03E8, 32'h0000_076C, 32'h00F4_2400};
   logic [31:0]      hi [3] = '{32'h0000_0BB8, 32'h0000_0834, 32'h017D_7840};

   always #2.5 core_clk = !core_clk;

   icc_top #(.MS_CYC(MSC)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .dio_i(dio_i), .dio_o(dio_o), .dio_oe(dio_oe), .irq(irq));

   icc_pin_src src (.core_clk(core_clk), .level(lvl), .run_mask(run), .half(16'h01F4), .dio_i(dio_i));

   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one access: hold until waitrequest is sampled low at a rising edge, then release
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
         report_and_stop();
      end
      r = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0000_0000, r);
   endtask

   task automatic commit;
      wr(A_CTRL, 32'h0000_0001);
   endtask

   task automatic pulse(input logic [7:0] m, input int l, input int h);
      lvl <= lvl & ~m;
      cyc(l);
      lvl <= lvl | m;
      cyc(h);
   endtask

   function automatic logic [31:0] fcfg(input logic [1:0] m, input logic [1:0] a);
      return (32'h0000_0004 << F_FREQEN) | ({30'h0, m} << F_MODE) | ({30'h0, a} << F_AVG);
   endfunction

   initial begin
      cyc(85000);
      err_count++;
      report_and_stop();
   end

   initial begin
      cyc(12);
      rst_n <= 1'b1;
      cyc(1);
      rd(A_FILT, q);
      `CHK(q[15:0], FILT_RST)
      rd(A_DIR, q);
      `CHK(q[7:0], DIR_RST)
      `CHK(dio_oe, 8'h00)
      rd(8'hFC, q);
      `CHK(q, 32'h0000_0000)
      // low latches set while inputs idle low
      lvl <= 8'hFF;
      cyc(4);
      wr(A_CTRL, 32'h0000_0000);
      rd(A_STAT, q);
      `CHK(q[7:0], 8'hFF)
      wr(A_CTRL, 32'h0000_0001 << B_CLRLO);
      rd(A_STAT, q);
      `CHK(q[7:0], 8'h00)
      `CHK(q[15:8], 8'hFF)
      rd(A_IRQS, q);
      `CHK(q[7:0], 8'hFF)
      `CHK(irq, 1'b0)
      wr(A_IRQM, 32'h0000_0001);
      `CHK(irq, 1'b1)
      wr(A_IRQS, 32'h0000_0001);
      `CHK(irq, 1'b0)
      lvl <= 8'hFE;
      cyc(4);
      `CHK(irq, 1'b1)
      rd(A_STAT, q);
      `CHK(q[7:0], 8'h01)
      lvl <= 8'hFF;
      // counters: preset, clear, enable, commit
      wr(A_PRESET, 32'h0000_0005);
      wr(A_PRESET + 8'h04, 32'h0000_0000);
      wr(A_CCLR, 32'h0000_0003);
      rd(A_COUNT, q);
      `CHK(q, 32'h0000_0005)
      wr(A_CFG, 32'h0000_0001);
      pulse(8'h01, 10, 10);
      rd(A_COUNT, q);
      `CHK(q, 32'h0000_0005)
      commit();
      for (int i = 0; i < 3; i++) pulse(8'h01, 10, 10);
      rd(A_COUNT, q);
      `CHK(q, 32'h0000_0008)
      // filter of 3 ms: 1 ms glitch dropped, 5 ms pulse kept
      wr(A_FILT, 32'h0000_0003);
      wr(A_CFG, 32'h0000_0002);
      commit();
      pulse(8'h03, 100, 20);
      pulse(8'h03, 100, 100);
      rd(A_COUNT + 8'h04, q);
      `CHK(q, 32'h0000_0001)
      rd(A_COUNT, q);
      `CHK(q, 32'h0000_0008)
      wr(A_FILT, 32'h0000_0000);
      // frequency on channel 2, 20 Hz per scaled second
      run <= 8'h04;
      for (int i = 0; i < 3; i++) begin
         wr(A_CFG, fcfg(md[i], 2'h0));
         commit();
         cyc(wt[i]);
         rd(A_FREQ + 8'h08, q);
         `CHK(q >= lo[i] && q <= hi[i], 1'b1)
      end
      for (int a = 1; a < 4; a++) begin
         wr(A_CFG, fcfg(MODE_SHORT, a[1:0]));
         commit();
         cyc(((1 << a) + 1) * 2000 + 500);
         rd(A_FREQ + 8'h08, q);
         `CHK(q >= lo[0] && q <= hi[0], 1'b1)
      end
      wr(A_CFG, 32'h0000_0000);
      commit();
      cyc(4);
      rd(A_FREQ + 8'h08, q);
      `CHK(q, 32'h0000_0000)
      run <= 8'h00;
      // outputs and direction
      wr(A_DOUT, 32'h0000_00A5);
      `CHK(dio_o, 8'hA5)
      wr(A_DIR, 32'h0000_000F);
      `CHK(dio_oe, 8'h00)
      commit();
      `CHK(dio_oe, 8'hF0)
      rd(A_STAT, q);
      `CHK(q[23:16], 8'h0F)
      wr(A_DIR, 32'h0000_00FF);
      wr(A_CFG, 32'h0000_0001 << B_DYN);
      commit();
      `CHK(dio_oe, 8'h00)
      wr(A_DOUT, 32'h0000_05A5);
      `CHK(dio_oe, 8'h05)
      `CHK(dio_o, 8'hA5)
      report_and_stop();
   end
endmodule
`default_nettype wire
